// ### hw/region_match.sv
`timescale 1ns/1ps
// one region's address match with subregion exclusion
module region_match (
  input  wire logic [31:0] base,
  input  wire logic [31:0] attr_size,
  input  wire logic [31:0] addr,
  output logic             hit
);
  logic [4:0]  size_field;
  logic [5:0]  span_log;
  logic [31:0] span_mask;
  logic [2:0]  sub_index;
  logic        sub_off;

  always_comb begin
    size_field = attr_size[region_prot_pkg::SIZE_MSB:region_prot_pkg::SIZE_LSB];
    span_log   = {1'b0, size_field} + 6'h01;
    // size 31 covers all of memory; a shift of 32 would leave all ones anyway
    span_mask  = (span_log >= 6'h20) ? 32'hffffffff : ((32'h00000001 << span_log) - 32'h00000001);
    sub_index  = 3'(addr >> (span_log - 6'h03));
    sub_off    = 1'b0;
    if (size_field >= region_prot_pkg::SIZE_SUBREGION_MIN) begin
      sub_off = attr_size[region_prot_pkg::SUBREGION_DISABLE_LSB + 32'(sub_index)];
    end
    hit = attr_size[region_prot_pkg::ENABLE_BIT]
          && (size_field >= region_prot_pkg::SIZE_MIN)
          && ((addr & ~span_mask) == (base & ~span_mask))
          && !sub_off;
  end
endmodule // region_match

// ### hw/region_prot_pkg.sv
package region_prot_pkg;

  // ----------------------------------------------------------------
  // register map on the private peripheral bus
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_REGION_SELECTOR   = 32'he000ed98;
  localparam logic [31:0] ADDR_REGION_BASE       = 32'he000ed9c;
  localparam logic [31:0] ADDR_REGION_ATTR_SIZE  = 32'he000eda0;
  localparam logic [31:0] ADDR_BASE_ALIAS1       = 32'he000eda4;
  localparam logic [31:0] ADDR_ATTR_ALIAS1       = 32'he000eda8;
  localparam logic [31:0] ADDR_BASE_ALIAS2       = 32'he000edac;
  localparam logic [31:0] ADDR_ATTR_ALIAS2       = 32'he000edb0;
  localparam logic [31:0] ADDR_BASE_ALIAS3       = 32'he000edb4;
  localparam logic [31:0] ADDR_ATTR_ALIAS3       = 32'he000edb8;

  // ----------------------------------------------------------------
  // region geometry and field layout
  // ----------------------------------------------------------------
  localparam int          REGION_COUNT     = 8;
  localparam int          REGION_IDX_W     = 3;
  localparam int          SEL_FIELD_W      = 8;
  localparam int          BASE_OVERRIDE_BIT = 4;
  localparam int          BASE_LOW_BIT     = 5;
  localparam int          ENABLE_BIT       = 0;
  localparam int          SIZE_LSB         = 1;
  localparam int          SIZE_MSB         = 5;
  localparam int          SUBREGION_DISABLE_LSB = 8;
  localparam int          SUBREGION_DISABLE_MSB = 15;
  localparam int          ATTR_LSB         = 16;
  localparam int          AP_LSB           = 24;
  localparam int          AP_MSB           = 26;
  localparam int          XN_BIT           = 28;
  localparam logic [4:0]  SIZE_MIN         = 5'h04;
  localparam logic [4:0]  SIZE_SUBREGION_MIN = 5'h07;
  localparam logic [31:0] BASE_WRITE_MASK  = 32'hffffffe0;
  localparam logic [31:0] ATTR_WRITE_MASK  = 32'h173fff3f;
  localparam logic [31:0] RESET_WORD       = 32'h00000000;

  // access permission encodings
  localparam logic [2:0]  AP_NONE          = 3'h0;
  localparam logic [2:0]  AP_PRIV_RW       = 3'h1;
  localparam logic [2:0]  AP_USER_RO       = 3'h2;
  localparam logic [2:0]  AP_FULL          = 3'h3;
  localparam logic [2:0]  AP_PRIV_RO       = 3'h5;

  // fault status layout
  localparam int          FAULT_ACCESS_VIOLATION = 0;
  localparam int          FAULT_NO_MATCH         = 1;
  localparam int          FAULT_FETCH            = 2;

endpackage

// ### hw/region_protection.sv
`timescale 1ns/1ps
module region_protection (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // register port from the core's peripheral bus
  input  wire logic        reg_valid,
  input  wire logic        reg_write,
  input  wire logic [31:0] reg_addr,
  input  wire logic [3:0]  reg_byte_en,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_ready,
  // protection enable controls
  input  wire logic        prot_enable,
  input  wire logic        background_enable,
  // access check port from the load/store and instruction fetch paths
  input  wire logic        chk_valid,
  input  wire logic [31:0] chk_addr,
  input  wire logic        chk_write,
  input  wire logic        chk_fetch,
  input  wire logic        chk_privileged,
  output logic             memory_management_fault,
  output logic [2:0]       fault_status,
  output logic [31:0]      fault_address,
  output logic             chk_done
);
  localparam int N = region_prot_pkg::REGION_COUNT;
  // region count is fixed; the selector keeps only the index bits

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [31:0] region_selector;
  logic [31:0] base_table [N];
  logic [31:0] attr_table [N];

  logic        full_word;
  logic        wr_en;
  logic        base_hit;
  logic        attr_hit;
  logic [1:0]  alias_slot;
  logic [3:0]  decoded;
  logic [7:0]  next_selector;
  logic [2:0]  target;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // selects register kind and alias index from the word offset past the selector
  function automatic logic [3:0] decode_offset(input logic [31:0] a);
    logic [31:0] delta;
    delta = a - region_prot_pkg::ADDR_REGION_SELECTOR;
    // result: {is_base, is_attr, slot}
    if (a < region_prot_pkg::ADDR_REGION_BASE || a > region_prot_pkg::ADDR_ATTR_ALIAS3) begin
      decode_offset = 4'h0;
    end else if (delta[2]) begin
      decode_offset = {2'b10, delta[4:3]};
    end else begin
      decode_offset = {2'b01, 2'(delta[4:3] - 2'h1)};
    end
  endfunction

  always_comb begin
    full_word  = (reg_byte_en == 4'hf) && (reg_addr[1:0] == 2'h0);
    wr_en      = reg_valid && reg_write && full_word;
    decoded    = decode_offset(reg_addr);
    base_hit   = decoded[3];
    attr_hit   = decoded[2];
    alias_slot = decoded[1:0];
    next_selector = region_selector[7:0];
    // only a write may steer the selector; a read's data lines carry nothing meaningful
    if (reg_write && base_hit && reg_wdata[region_prot_pkg::BASE_OVERRIDE_BIT]) begin
      next_selector = {4'h0, reg_wdata[3:0]};
    end
    // alias pairs index relative to the selector's lower two bits
    target = {next_selector[2], 2'(next_selector[1:0] + alias_slot)};
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // selector: written directly or through a base write carrying a region number
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      region_selector <= region_prot_pkg::RESET_WORD;
    end else if (wr_en && reg_addr == region_prot_pkg::ADDR_REGION_SELECTOR) begin
      region_selector <= {24'h000000, 5'h00, reg_wdata[region_prot_pkg::REGION_IDX_W-1:0]};
    end else if (wr_en && base_hit && reg_wdata[region_prot_pkg::BASE_OVERRIDE_BIT]) begin
      region_selector <= {24'h000000, 5'h00, reg_wdata[region_prot_pkg::REGION_IDX_W-1:0]};
    end
  end

  // region tables; one write per cycle keeps a burst strictly in order
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < N; i++) begin
        base_table[i] <= region_prot_pkg::RESET_WORD;
        attr_table[i] <= region_prot_pkg::RESET_WORD;
      end
    end else if (wr_en && base_hit) begin
      base_table[target] <= reg_wdata & region_prot_pkg::BASE_WRITE_MASK;
    end else if (wr_en && attr_hit) begin
      attr_table[target] <= reg_wdata & region_prot_pkg::ATTR_WRITE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // register read and completion
  // ----------------------------------------------------------------
  // every access completes next cycle, so back-to-back stores stay ordered
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_ready <= 1'b0;
      reg_rdata <= region_prot_pkg::RESET_WORD;
    end else begin
      reg_ready <= reg_valid;
      reg_rdata <= region_prot_pkg::RESET_WORD;
      if (reg_valid && !reg_write && full_word) begin
        if (reg_addr == region_prot_pkg::ADDR_REGION_SELECTOR) begin
          reg_rdata <= region_selector;
        end else if (base_hit) begin
          // base reads show the region number in the low bits, like the override field
          reg_rdata <= base_table[target] | {27'h0000000, 1'b0, 1'b0, target[2:0] & 3'h7} ;
        end else if (attr_hit) begin
          reg_rdata <= attr_table[target];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // access check
  // ----------------------------------------------------------------
  logic [N-1:0] hits;
  logic         any_hit;
  logic [2:0]   win;
  logic [2:0]   ap;
  logic         xn;
  logic         deny;
  logic         no_match;

  // matching is combinational on the live tables, so a write counts from the next access
  for (genvar g = 0; g < N; g++) begin : g_match
    region_match u_match (
      .base      (base_table[g]),
      .attr_size (attr_table[g]),
      .addr      (chk_addr),
      .hit       (hits[g])
    );
  end

  // permission table for one access
  // reserved code 4 falls to no access, so a bad setup fails closed
  function automatic logic permit(input logic [2:0] a, input logic priv, input logic wr);
    unique case (a)
      region_prot_pkg::AP_PRIV_RW: permit = priv;
      region_prot_pkg::AP_USER_RO: permit = priv || !wr;
      region_prot_pkg::AP_FULL:    permit = 1'b1;
      region_prot_pkg::AP_PRIV_RO: permit = priv && !wr;
      3'h6, 3'h7:                  permit = !wr;
      default:                     permit = 1'b0;
    endcase
  endfunction

  // highest numbered matching region wins, as with overlapping regions
  always_comb begin
    any_hit = |hits;
    win     = 3'h0;
    for (int i = 0; i < N; i++) begin
      if (hits[i]) begin
        win = 3'(i);
      end
    end
    ap       = attr_table[win][region_prot_pkg::AP_MSB:region_prot_pkg::AP_LSB];
    xn       = attr_table[win][region_prot_pkg::XN_BIT];
    // a privileged miss may fall back to the background map when it is on
    no_match = !any_hit && (!chk_privileged || !background_enable);
    deny     = any_hit && (!permit(ap, chk_privileged, chk_write) || (chk_fetch && xn));
  end

  // ----------------------------------------------------------------
  // fault report
  // ----------------------------------------------------------------
  // status and address hold the last fault so a handler can read them late
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      memory_management_fault <= 1'b0;
      fault_status            <= 3'h0;
      fault_address           <= region_prot_pkg::RESET_WORD;
      chk_done                <= 1'b0;
    end else begin
      chk_done                <= chk_valid;
      memory_management_fault <= chk_valid && prot_enable && (deny || no_match);
      if (chk_valid && prot_enable && (deny || no_match)) begin
        fault_status[region_prot_pkg::FAULT_ACCESS_VIOLATION] <= deny;
        fault_status[region_prot_pkg::FAULT_NO_MATCH]         <= no_match;
        fault_status[region_prot_pkg::FAULT_FETCH]            <= chk_fetch;
        fault_address                                          <= chk_addr;
      end
    end
  end
endmodule // region_protection

// ### test/core_model.sv
`timescale 1ns/1ps
// core side: one register or check request at a time, with the byte enables each call passes in
module core_model (
  input  wire logic        clk,
  input  wire logic        reg_ready,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        memory_management_fault,
  input  wire logic        chk_done,
  output logic             reg_valid = 1'b0,
  output logic             reg_write = 1'b0,
  output logic [31:0]      reg_addr = 32'h0,
  output logic [3:0]       reg_byte_en = 4'hf,
  output logic [31:0]      reg_wdata = 32'h0,
  output logic             chk_valid = 1'b0,
  output logic [31:0]      chk_addr = 32'h0,
  output logic             chk_write = 1'b0,
  output logic             chk_fetch = 1'b0,
  output logic             chk_privileged = 1'b0
);
  // each request holds for one clock and then samples the answer, so no write is left outstanding around a setup
  task automatic acc(input logic w, input logic [31:0] a, input logic [3:0] be, input logic [31:0] d,
                     output logic [31:0] rd, output logic rdy);
    @(posedge clk);
    #1;
    reg_valid = 1'b1;
    reg_write = w;
    reg_addr = a;
    reg_byte_en = be;
    reg_wdata = d;
    @(posedge clk);
    #1;
    rd = reg_rdata;
    rdy = reg_ready;
    reg_valid = 1'b0;
    // released address and data lines show the inverse so stale values cannot pass
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // no check runs while a region update is in flight, as with interrupts masked
  task automatic chk(input logic [31:0] a, input logic p, input logic w, input logic x, output logic f,
                     output logic dn);
    @(posedge clk);
    #1;
    chk_valid = 1'b1;
    chk_addr = a;
    chk_privileged = p;
    chk_write = w;
    chk_fetch = x;
    @(posedge clk);
    #1;
    f = memory_management_fault;
    dn = chk_done;
    chk_valid = 1'b0;
    chk_addr = ~a;
  endtask
endmodule // core_model

// ### test/region_prot_checker.sv
`timescale 1ns/1ps
module region_prot_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        reg_valid,
  input wire logic        reg_write,
  input wire logic [3:0]  reg_byte_en,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_ready,
  input wire logic        prot_enable,
  input wire logic        background_enable,
  input wire logic        chk_valid,
  input wire logic        chk_privileged,
  input wire logic        memory_management_fault,
  input wire logic [2:0]  fault_status,
  input wire logic        chk_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence reg_req;
    reg_valid;
  endsequence
  sequence chk_req;
    chk_valid;
  endsequence
  ready_follows_a: assert property (reg_req |=> reg_ready)
    else $error("register answer missing");
  ready_cause_a: assert property (reg_ready |-> $past(reg_valid))
    else $error("register answer without request");
  rdata_idle_a: assert property (!reg_ready |-> reg_rdata == 32'h0)
    else $error("read data outside answer");
  partial_read_a: assert property (reg_valid && !reg_write && reg_byte_en != 4'hf |=> reg_rdata == 32'h0)
    else $error("partial read returned data");
  done_follows_a: assert property (chk_req |=> chk_done)
    else $error("check answer missing");
  fault_timing_a: assert property (memory_management_fault |-> chk_done && $past(prot_enable))
    else $error("fault outside check answer");
  background_pass_a: assert property (memory_management_fault && fault_status[1]
    |-> !$past(chk_privileged && background_enable))
    else $error("background access faulted");
  status_hold_a: assert property (!memory_management_fault |-> $stable(fault_status))
    else $error("fault status moved without fault");
endmodule // region_prot_checker

bind region_protection region_prot_checker u_chk (.clk, .sys_rst, .reg_valid, .reg_write, .reg_byte_en,
  .reg_rdata, .reg_ready, .prot_enable, .background_enable, .chk_valid, .chk_privileged,
  .memory_management_fault, .fault_status, .chk_done);

// ### test/test_region_protection.sv
`timescale 1ns/1ps
module test_region_protection;
  localparam logic [31:0] SEL = region_prot_pkg::ADDR_REGION_SELECTOR;
  localparam logic [31:0] BASE = region_prot_pkg::ADDR_REGION_BASE;
  localparam logic [31:0] ATTR = region_prot_pkg::ADDR_REGION_ATTR_SIZE;
  logic clk = 1'b0, sys_rst = 1'b1, prot_enable = 1'b1, background_enable = 1'b0;
  logic reg_valid, reg_write, reg_ready, chk_valid, chk_write, chk_fetch, chk_privileged;
  logic memory_management_fault, chk_done;
  logic [3:0] reg_byte_en;
  logic [2:0] fault_status;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, chk_addr, fault_address;
  int n_errors = 0, checks_done = 0;
  region_protection dut (.clk, .sys_rst, .reg_valid, .reg_write, .reg_addr, .reg_byte_en, .reg_wdata,
    .reg_rdata, .reg_ready, .prot_enable, .background_enable, .chk_valid, .chk_addr, .chk_write, .chk_fetch,
    .chk_privileged, .memory_management_fault, .fault_status, .fault_address, .chk_done);
  core_model core (.clk, .reg_ready, .reg_rdata, .memory_management_fault, .chk_done, .reg_valid, .reg_write,
    .reg_addr,
    .reg_byte_en, .reg_wdata, .chk_valid, .chk_addr, .chk_write, .chk_fetch, .chk_privileged);
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    logic [31:0] r;
    logic y;
    core.acc(1'b1, a, be, d, r, y);
    cmp("ready", 32'h1, {31'h0, y});
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [3:0] be = 4'hf);
    logic [31:0] r;
    logic y;
    core.acc(1'b0, a, be, 32'h0, r, y);
    cmp("rdata", e, r);
    cmp("read ready", 32'h1, {31'h0, y});
  endtask
  task automatic ck(input logic [31:0] a, input logic p, input logic e, input logic w = 1'b0,
                    input logic x = 1'b0);
    logic f;
    logic dn;
    core.chk(a, p, w, x, f, dn);
    cmp("fault", {31'h0, e}, {31'h0, f});
    cmp("chk_done", 32'h1, {31'h0, dn});
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    rd(SEL, 32'h0);
    rd(ATTR, 32'h0);
    wr(SEL, 32'h2);
    wr(BASE, 32'h20000000);
    wr(ATTR, 32'h03000013);
    rd(SEL, 32'h2);
    rd(BASE, 32'h20000002);
    rd(ATTR, 32'h03000013);
    ck(32'h200003fc, 1'b0, 1'b0);
    ck(32'h20000400, 1'b0, 1'b1);
    cmp("status", 32'h2, {29'h0, fault_status});
    cmp("address", 32'h20000400, fault_address);
    wr(BASE, 32'h30000015);
    wr(ATTR, 32'h03008111);
    rd(SEL, 32'h5);
    for (int i = 0; i < 8; i++) begin
      ck(32'h30000000 + i * 64, 1'b0, i == 0 || i == 7);
    end
    background_enable = 1'b1;
    ck(32'h30000000, 1'b1, 1'b0);
    ck(32'h30000000, 1'b0, 1'b1);
    background_enable = 1'b0;
    ck(32'h30000000, 1'b1, 1'b1);
    wr(SEL, 32'h0);
    for (int k = 1; k < 4; k++) begin
      wr(region_prot_pkg::ADDR_BASE_ALIAS1 + 8 * (k - 1), 32'h40000000 + (k << 16));
      wr(region_prot_pkg::ADDR_ATTR_ALIAS1 + 8 * (k - 1), 32'h03000013);
    end
    for (int k = 1; k < 4; k++) begin
      wr(SEL, k);
      rd(BASE, 32'h40000000 + (k << 16) + k);
      ck(32'h40000000 + (k << 16), 1'b0, 1'b0);
    end
    // region 1 is taken down before reuse, as software must
    wr(SEL, 32'h1);
    wr(ATTR, 32'h03000012);
    ck(32'h40010000, 1'b0, 1'b1);
    wr(SEL, 32'h6, 4'h1);
    rd(SEL, 32'h1);
    rd(SEL, 32'h0, 4'h3);
    rd(32'he000edbc, 32'h0);
    // region 6: privileged read only, no execution, programmed in two words
    wr(BASE, 32'h60000016);
    wr(ATTR, 32'h15000013);
    ck(32'h60000000, 1'b1, 1'b0);
    ck(32'h60000000, 1'b1, 1'b1, 1'b1);
    cmp("status", 32'h1, {29'h0, fault_status});
    ck(32'h60000000, 1'b0, 1'b1);
    ck(32'h60000000, 1'b1, 1'b1, 1'b0, 1'b1);
    cmp("status", 32'h5, {29'h0, fault_status});
    // smallest region, subregion field left zero as software must
    wr(BASE, 32'h70000017);
    wr(ATTR, 32'h03000009);
    ck(32'h7000001c, 1'b0, 1'b0);
    ck(32'h70000020, 1'b0, 1'b1);
    prot_enable = 1'b0;
    ck(32'h50000000, 1'b0, 1'b0);
    complete_run;
  end
endmodule // test_region_protection
